// ### design/sbs_core.v
// Synchronous burst SRAM core with pin-level host interface and an AXI4-Lite control/status port.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.vh"

module sbs_core (
	input wire clk_sys,
	input wire reset,
	input wire sram_clock,
	input wire chip_select_n,
	input wire processor_address_strobe_n,
	input wire controller_address_strobe_n,
	input wire burst_advance_n,
	input wire byte_write_enable_n,
	input wire all_byte_write_n,
	input wire [`SBS_LANES-1:0] byte_lane_select_n,
	input wire output_enable_n,
	input wire sleep_request,
	input wire linear_order_select_n,
	input wire single_deselect_select,
	input wire drive_strength_select_n,
	input wire parity_lane_on_n,
	input wire [`SBS_ADDR_W-1:0] sram_addr,
	input wire [`SBS_DATA_W-1:0] dq_in,
	output reg [`SBS_DATA_W-1:0] dq_out,
	output wire [`SBS_DATA_W-1:0] dq_oe,
	output reg high_drive,
	output wire sleeping,
	input wire [`SBS_AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`SBS_AXI_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// Every pin except output enable crosses into clk_sys through two flip-flops as one vector, so all fields
	// seen at a detected SRAM clock edge were sampled at the same clk_sys instant.
	wire [`SBS_PIN_W-1:0] pin_raw;
	reg [`SBS_PIN_W-1:0] pin_s1_q;
	reg [`SBS_PIN_W-1:0] pin_s2_q;
	wire ck_s;
	wire cs_n_s;
	wire processor_address_strobe_n_s;
	wire controller_address_strobe_n_s;
	wire adv_n_s;
	wire bwe_n_s;
	wire gw_n_s;
	wire [`SBS_LANES-1:0] lane_n_s;
	wire sleep_s;
	wire lin_n_s;
	wire scd_s;
	wire zq_n_s;
	wire pe_n_s;
	wire [`SBS_ADDR_W-1:0] addr_s;
	wire [`SBS_DATA_W-1:0] din_s;

	assign pin_raw = {sram_clock, chip_select_n, processor_address_strobe_n, controller_address_strobe_n,
		burst_advance_n, byte_write_enable_n, all_byte_write_n, byte_lane_select_n, sleep_request,
		linear_order_select_n, single_deselect_select, drive_strength_select_n, parity_lane_on_n,
		sram_addr, dq_in};
	assign {ck_s, cs_n_s, processor_address_strobe_n_s, controller_address_strobe_n_s, adv_n_s, bwe_n_s, gw_n_s, lane_n_s, sleep_s,
		lin_n_s, scd_s, zq_n_s, pe_n_s, addr_s, din_s} = pin_s2_q;

	// Resetting the synchroniser to zeros shows a low SRAM clock and a low sleep pin, so an SRAM clock
	// that is high when reset ends gives one capture edge, and an open, pulled-down sleep pin means active.
	always @(posedge clk_sys) begin
		if (reset) begin
			pin_s1_q <= {`SBS_PIN_W{1'b0}};
			pin_s2_q <= {`SBS_PIN_W{1'b0}};
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Control register state.
	reg ctrl_sleep_q;
	reg ctrl_par_off_q;
	reg [31:0] wr_cnt_q;
	reg cnt_clr_q;

	// Core state.
	reg [`SBS_DATA_W-1:0] mem [0:`SBS_DEPTH-1];
	reg ck_prev_q;
	reg [`SBS_ADDR_W-1:0] base_q;
	reg [1:0] step_q;
	reg active_q;
	reg drive_q;
	reg desel_pend_q;
	reg [`SBS_ADDR_W-1:0] last_addr_q;

	wire ck_rise;
	wire sleep_eff;
	wire parity_en;
	wire do_desel;
	wire do_load;
	wire do_cont;
	wire wr_cmd;
	wire op_wr;
	wire op_rd;
	wire [1:0] step_nx;
	wire [1:0] low_nx;
	wire [`SBS_ADDR_W-1:0] op_addr;
	wire [`SBS_LANES-1:0] lane_wr;
	wire [`SBS_DATA_W-1:0] mem_word;
	wire [`SBS_DATA_W-1:0] merged;
	wire [`SBS_DATA_W-1:0] lane_mask;

	assign ck_rise = ck_s & ~ck_prev_q;
	// A stopped SRAM clock simply yields no edges, so no access or burst step takes place.
	assign sleep_eff = sleep_s | ctrl_sleep_q;
	assign sleeping = sleep_eff;
	assign parity_en = ~pe_n_s & ~ctrl_par_off_q;

	// Command decode. The three cases partition the strobe combinations.
	assign do_desel = cs_n_s & ~controller_address_strobe_n_s;
	assign do_load = ~cs_n_s & (~processor_address_strobe_n_s | ~controller_address_strobe_n_s);
	// A continue or suspend cycle needs both strobes inactive, or the controller strobe
	// inactive while the chip is deselected. With no burst under way it is ignored.
	assign do_cont = controller_address_strobe_n_s & (processor_address_strobe_n_s | cs_n_s) & active_q;

	// Write decode; a cycle started by the processor strobe is always a read.
	assign lane_wr = ~gw_n_s ? {`SBS_LANES{1'b1}} : (bwe_n_s ? {`SBS_LANES{1'b0}} : ~lane_n_s);
	assign wr_cmd = |lane_wr;
	assign op_wr = ck_rise & ~sleep_eff & wr_cmd & ((do_load & processor_address_strobe_n_s) | do_cont);
	// Output enable plays no part here, so a dummy read steps the counter like any read.
	assign op_rd = ck_rise & ~sleep_eff & ~op_wr & (do_load | do_cont);

	// Burst counter: two bits, so it wraps to the start after four addresses.
	assign step_nx = adv_n_s ? step_q : step_q + 2'h1;
	assign low_nx = lin_n_s ? (base_q[1:0] ^ step_nx) : (base_q[1:0] + step_nx);
	// A load feeds the pin address straight into the access, so a new address costs no cycle.
	assign op_addr = do_load ? addr_s : {base_q[`SBS_ADDR_W-1:2], low_nx};
	assign mem_word = mem[op_addr];

	genvar g;
	generate
		for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
			// The ninth bit of a lane is only stored and driven while parity lanes are on.
			assign lane_mask[g*`SBS_LANE_W +: `SBS_LANE_W] = {parity_en, 8'hff};
			assign merged[g*`SBS_LANE_W +: `SBS_LANE_W] = lane_wr[g] ?
				(din_s[g*`SBS_LANE_W +: `SBS_LANE_W] & {parity_en, 8'hff}) :
				mem_word[g*`SBS_LANE_W +: `SBS_LANE_W];
		end
	endgenerate

	// The drivers follow the registered read state, but output enable and the sleep pin
	// gate them directly so that either can shut the bus without a clock edge.
	assign dq_oe = {`SBS_DATA_W{drive_q & ~output_enable_n & ~sleep_request}} & lane_mask;

	// Neither reset nor sleep touches the array, so stored words survive both.
	always @(posedge clk_sys) begin
		if (op_wr) begin
			mem[op_addr] <= merged;
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			ck_prev_q <= 1'b0;
			base_q <= {`SBS_ADDR_W{1'b0}};
			step_q <= 2'h0;
			active_q <= 1'b0;
			drive_q <= 1'b0;
			desel_pend_q <= 1'b0;
			last_addr_q <= {`SBS_ADDR_W{1'b0}};
			dq_out <= {`SBS_DATA_W{1'b0}};
			high_drive <= 1'b0;
			wr_cnt_q <= 32'h0;
		end else begin
			ck_prev_q <= ck_s;
			// The drive pin only picks a pad setting, so a registered copy of it is enough.
			high_drive <= ~zq_n_s;
			// A clear wins over a write in the same cycle; that one write goes uncounted.
			if (cnt_clr_q) begin
				wr_cnt_q <= 32'h0;
			end else if (op_wr) begin
				wr_cnt_q <= wr_cnt_q + 32'h1;
			end
			if (sleep_eff) begin
				drive_q <= 1'b0;
				active_q <= 1'b0;
				desel_pend_q <= 1'b0;
			end else if (ck_rise) begin
				desel_pend_q <= 1'b0;
				if (do_load) begin
					base_q <= addr_s;
					step_q <= 2'h0;
					active_q <= 1'b1;
				end else if (do_cont) begin
					step_q <= step_nx;
				end else if (do_desel) begin
					active_q <= 1'b0;
				end
				if (do_load | do_cont) begin
					last_addr_q <= op_addr;
				end
				if (op_wr) begin
					drive_q <= 1'b0;
				end else if (op_rd) begin
					// Read data stays here until the next read, whether or not it is driven.
					dq_out <= mem_word & lane_mask;
					drive_q <= 1'b1;
				end else if (do_desel) begin
					if (scd_s) begin
						drive_q <= 1'b0;
					end else if (desel_pend_q) begin
						// A deselect already held one cycle turns the drivers off here; arming
						// the hold again would keep stale read data on the bus.
						drive_q <= 1'b0;
					end else begin
						desel_pend_q <= 1'b1;
					end
				end else if (desel_pend_q) begin
					drive_q <= 1'b0;
				end
			end
		end
	end

	// AXI4-Lite slave. Address and data are latched separately and the write is done once
	// both are held, so the master may present them in either order.
	reg aw_have_q;
	reg w_have_q;
	reg [`SBS_AXI_ADDR_W-1:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire wr_go;
	wire [11:0] status_bits;

	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

	// Status word, from bit 11 down to bit 0.
	assign status_bits = {
		parity_en,
		high_drive,
		~lin_n_s,
		scd_s,
		sleep_eff,
		desel_pend_q,
		active_q,
		drive_q,
		step_q,
		low_nx
	};

	always @* begin
		rd_mux = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`SBS_REG_CTRL: begin
				rd_mux = {30'h0, ctrl_par_off_q, ctrl_sleep_q};
			end
			`SBS_REG_STATUS: begin
				rd_mux = {20'h0, status_bits};
			end
			`SBS_REG_ADDR: begin
				rd_mux = {{(32-`SBS_ADDR_W){1'b0}}, last_addr_q};
			end
			`SBS_REG_WRCNT: begin
				rd_mux = wr_cnt_q;
			end
			default: begin
				// Unmapped offsets read as zero with an error response.
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= {`SBS_AXI_ADDR_W{1'b0}};
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SBS_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SBS_RESP_OKAY;
			s_axi_rdata <= 32'h0;
			ctrl_sleep_q <= 1'b0;
			ctrl_par_off_q <= 1'b0;
			cnt_clr_q <= 1'b0;
		end else begin
			cnt_clr_q <= 1'b0;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SBS_RESP_OKAY;
				case (aw_addr_q)
					`SBS_REG_CTRL: begin
						if (w_strb_q[0]) begin
							ctrl_sleep_q <= w_data_q[`SBS_CTRL_SLEEP_BIT];
							ctrl_par_off_q <= w_data_q[`SBS_CTRL_PAR_OFF_BIT];
							cnt_clr_q <= w_data_q[`SBS_CTRL_CNT_CLR_BIT];
						end
					end
					`SBS_REG_STATUS, `SBS_REG_ADDR, `SBS_REG_WRCNT: begin
						// Read-only registers accept a write and ignore it.
						s_axi_bresp <= `SBS_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `SBS_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### inc/sbs_regs.vh
// Constants for the synchronous burst SRAM core: widths, register map, fields and reset values.
`ifndef SBS_REGS_VH
`define SBS_REGS_VH

`define SBS_ADDR_W 18
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_DEPTH 262144
`define SBS_PIN_W 70

`define SBS_REG_CTRL 4'h0
`define SBS_REG_STATUS 4'h4
`define SBS_REG_ADDR 4'h8
`define SBS_REG_WRCNT 4'hc
`define SBS_AXI_ADDR_W 4

`define SBS_CTRL_SLEEP_BIT 0
`define SBS_CTRL_PAR_OFF_BIT 1
`define SBS_CTRL_CNT_CLR_BIT 2
`define SBS_CTRL_RESET 2'h0

`define SBS_RESP_OKAY 2'h0
`define SBS_RESP_SLVERR 2'h2

`endif

// ### tb/sbs_core_sva.sv
// Checker of the pin timing rules of the burst SRAM core.
`timescale 1ns/10ps
`default_nettype none
module sbs_core_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sram_clock,
	input wire logic chip_select_n,
	input wire logic processor_address_strobe_n,
	input wire logic controller_address_strobe_n,
	input wire logic byte_write_enable_n,
	input wire logic all_byte_write_n,
	input wire logic [3:0] byte_lane_select_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic single_deselect_select,
	input wire logic parity_lane_on_n,
	input wire logic [35:0] dq_oe,
	input wire logic sleeping
);
	localparam logic [35:0] par_bits = 36'h804020100;
	logic s1_q, s2_q, s3_q, rd_last_q;
	// The pin clock is watched through the same two flops as the core, so events line up.
	wire ev = s2_q & ~s3_q;
	wire wr = ~all_byte_write_n | (~byte_write_enable_n & (byte_lane_select_n != 4'hf));
	wire cont = processor_address_strobe_n & controller_address_strobe_n;
	wire rd_ev = ev & ~wr & (cont | ~chip_select_n & ~controller_address_strobe_n) | ev & ~chip_select_n & ~processor_address_strobe_n;
	wire wr_ev = ev & wr & ~chip_select_n & processor_address_strobe_n & ~controller_address_strobe_n;
	wire ds_ev = ev & chip_select_n & ~controller_address_strobe_n;
	always @(posedge clk_sys) begin
		s1_q <= sram_clock;
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (reset)
			rd_last_q <= 1'b0;
		else if (ev)
			rd_last_q <= rd_ev;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_rd; rd_ev && !sleeping && !output_enable_n && !sleep_request; endsequence
	sequence s_dual; ds_ev && !single_deselect_select; endsequence
	property p_rd_drive; s_rd |-> ##2 dq_oe[7:0] == 8'hff; endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read left outputs off");
	property p_wr_off; wr_ev |-> ##2 dq_oe == '0; endproperty
	a_wr_off: assert property (p_wr_off) else $error("outputs driven after write");
	property p_scd; ds_ev && single_deselect_select |-> ##2 dq_oe == '0; endproperty
	a_scd: assert property (p_scd) else $error("single deselect kept outputs on");
	property p_dcd_hold; s_dual and rd_last_q && dq_oe[0] |-> ##2 dq_oe[0]; endproperty
	a_dcd_hold: assert property (p_dcd_hold) else $error("dual deselect dropped outputs early");
	property p_dcd_off; s_dual and !rd_last_q |-> ##2 dq_oe == '0; endproperty
	a_dcd_off: assert property (p_dcd_off) else $error("second deselect kept outputs on");
	property p_oe; output_enable_n || sleep_request |-> dq_oe == '0; endproperty
	a_oe: assert property (p_oe) else $error("outputs on while disabled");
	property p_par; parity_lane_on_n |-> (dq_oe & par_bits) == '0; endproperty
	a_par: assert property (p_par) else $error("parity bit driven while off");
	property p_lanes; dq_oe[0] |-> (dq_oe | par_bits) == '1; endproperty
	a_lanes: assert property (p_lanes) else $error("not all lanes driven");
	property p_sleep; sleep_request [*3] |-> sleeping; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep request ignored");
endmodule
bind sbs_core sbs_core_sva sva_u (.*);
`default_nettype wire

// ### tb/sbs_host.sv
// Pin-level host controller model that runs one SRAM clock cycle per call.
`timescale 1ns/10ps
`default_nettype none
module sbs_host (
	input wire logic clk_sys,
	output logic sram_clock = 1'b0,
	output logic chip_select_n = 1'b1,
	output logic processor_address_strobe_n = 1'b1,
	output logic controller_address_strobe_n = 1'b1,
	output logic burst_advance_n = 1'b1,
	output logic byte_write_enable_n = 1'b1,
	output logic all_byte_write_n = 1'b1,
	output logic [3:0] byte_lane_select_n = 4'hf,
	output logic [17:0] sram_addr = 18'h0,
	output logic [35:0] dq_in = 36'h0
);
	// Ops: 0 strobe-c begin, 1 strobe-p read, 2 byte write, 3 all write, 4 continue, 5 suspend, 6 deselect.
	task automatic cyc(input int op, input logic [17:0] a, input logic [35:0] d, input logic [3:0] sel, input logic bw);
		@(posedge clk_sys);
		chip_select_n <= op > 3 && op != 6 || op == 6;
		processor_address_strobe_n <= op != 1;
		controller_address_strobe_n <= !(op == 0 || op == 2 || op == 3 || op == 6);
		burst_advance_n <= op != 4;
		byte_write_enable_n <= op == 2 || op == 3 ? bw : 1'b1;
		all_byte_write_n <= op != 3;
		byte_lane_select_n <= sel;
		sram_addr <= a;
		dq_in <= d;
		@(posedge clk_sys);
		sram_clock <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sram_clock <= 1'b0;
		repeat (3) @(posedge clk_sys);
		// The hold time is over, so the data lines stop showing the written value.
		dq_in <= ~d;
	endtask
endmodule
`default_nettype wire

// ### tb/test_sbs_core.sv
// Self-checking bench of the burst SRAM core with a reference model.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.vh"
module test_sbs_core;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic output_enable_n = 1'b0, sleep_request = 1'b0, linear_order_select_n = 1'b0, parity_lane_on_n = 1'b0;
	logic single_deselect_select = 1'b1, drive_strength_select_n = 1'b1, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic sram_clock, chip_select_n, processor_address_strobe_n, controller_address_strobe_n, burst_advance_n;
	logic byte_write_enable_n, all_byte_write_n, high_drive, sleeping, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [3:0] byte_lane_select_n;
	logic [17:0] sram_addr;
	logic [35:0] dq_in, dq_out, dq_oe, mem [0:7];
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int fails = 0, check_count = 0, cycles = 0, base, step, wcnt, op, ix, la;
	bit act, drv, pend;
	sbs_host host_u (.*);
	sbs_core dut_u (.*);
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			conclude();
		end
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= wd;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {wr, wr, wr, !wr, !wr};
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid)
				break;
		end
		rd = s_axi_rdata;
		chk(wr ? s_axi_bresp : s_axi_rresp, 0);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		logic [63:0] r;
		logic [35:0] pm, wm;
		logic [31:0] rd;
		seed = 32'hb74d;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		axi(0, `SBS_REG_CTRL, 0, rd);
		chk(rd, 0);
		axi(1, `SBS_REG_CTRL, 1, rd);
		chk(sleeping, 1);
		axi(1, `SBS_REG_CTRL, 0, rd);
		chk(sleeping, 0);
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			r = {$random(seed), $random(seed)};
			host_u.cyc(3, 18'(i), r[35:0], r[39:36], r[40]);
			mem[i] = r[35:0];
		end
		wcnt = 8;
		la = 7;
		for (int m = 0; m < 8; m++) begin
			{single_deselect_select, linear_order_select_n, parity_lane_on_n} <= m[2:0];
			drive_strength_select_n <= m[0] ^ m[1];
			sleep_request <= 1'b1;
			host_u.cyc(3, 0, ~mem[0], 0, 0);
			chk(sleeping, 1);
			chk(dq_oe, 0);
			sleep_request <= 1'b0;
			repeat (3) @(posedge clk_sys);
			{act, drv, pend} = 3'b000;
			pm = parity_lane_on_n ? 36'h7fbfdfeff : '1;
			for (int k = 0; k < 12; k++) begin
				r = {$random(seed), $random(seed)};
				op = r[47:44] % 7;
				if (!act && op > 3 && op < 6)
					op = 0;
				output_enable_n <= r[49:48] == 2'h0;
				host_u.cyc(op, {15'h0, r[38:36]}, r[35:0], r[42:39], r[43]);
				if (op < 4) begin
					base = r[38:36];
					step = 0;
					act = 1;
				end
				if (op == 4)
					step = (step + 1) % 4;
				if (op == 6) begin
					act = 0;
					drv = !single_deselect_select && drv && !pend;
					pend = drv;
				end else if (op == 3 || op == 2 && !r[43] && r[42:39] != 4'hf) begin
					wm = '1;
					for (int g = 0; g < 4; g++)
						if (op == 2 && r[39 + g])
							wm[9 * g +: 9] = 9'h0;
					mem[base] = mem[base] & ~wm | r[35:0] & wm & pm;
					wcnt++;
					la = base;
					{drv, pend} = 2'b00;
				end else begin
					ix = linear_order_select_n ? base ^ step : base & 4 | (base + step) & 3;
					chk(dq_out, mem[ix] & pm);
					la = ix;
					{drv, pend} = 2'b10;
				end
				chk(dq_oe, drv && !output_enable_n ? pm : 0);
			end
			chk(high_drive, !drive_strength_select_n);
			$display("mode %0d done", m);
		end
		axi(0, `SBS_REG_WRCNT, 0, rd);
		chk(rd, wcnt);
		axi(0, `SBS_REG_ADDR, 0, rd);
		chk(rd, la);
		axi(1, `SBS_REG_CTRL, 4, rd);
		axi(0, `SBS_REG_WRCNT, 0, rd);
		chk(rd, 0);
		$display("write count test done");
		conclude();
	end
endmodule
`default_nettype wire
